// ---- rtl/atsm_apb.v ----
`timescale 1ns/1ps
`include "atsm_defs.vh"
// apb register slave: zero wait states, error on unmapped addresses
module atsm_apb (
	input  wire        pclk,
	input  wire        presetn,
	input  wire [11:0] paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire [15:0] status,
	output reg  [7:0]  txctl,
	output reg  [7:0]  pin_sel,
	output reg  [7:0]  ch3_cfg,
	output reg  [7:0]  ch4_cfg,
	output reg  [7:0]  fmt
);
	wire [7:0]  idx;    // word index from the byte address
	wire        align;  // low and high address bits clear
	reg         hit;    // address maps to a register
	reg  [31:0] rd_mux; // read value for the addressed register
	wire        wr;     // write takes effect this edge

	assign idx     = paddr[9:2];
	assign align   = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign wr      = psel & penable & pwrite & hit;

	// decode and read mux; unused bits read as zero
	always @*
	begin
		hit    = align;
		rd_mux = 32'h00000000;
		case (idx)
			`ATSM_IDX_TXCTL:  rd_mux[7:0] = txctl;
			`ATSM_IDX_PINSEL: rd_mux[7:0] = pin_sel;
			`ATSM_IDX_CH3:    rd_mux[7:0] = ch3_cfg;
			`ATSM_IDX_CH4:    rd_mux[7:0] = ch4_cfg;
			`ATSM_IDX_FMT:    rd_mux[7:0] = fmt;
			`ATSM_IDX_STAT:   rd_mux[15:0] = status;
			default:          hit = 1'b0;
		endcase
		if (!align)
			rd_mux = 32'h00000000;
	end

	// read data is captured in the setup cycle so it stands in access
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel && !penable && !pwrite)
			prdata <= rd_mux;
	end

	// register writes; reserved bits are never stored
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			txctl   <= `ATSM_RST_TXCTL;
			pin_sel <= `ATSM_RST_PINSEL;
			ch3_cfg <= `ATSM_RST_CH3;
			ch4_cfg <= `ATSM_RST_CH4;
			fmt     <= `ATSM_RST_FMT;
		end
		else if (wr)
		begin
			case (idx)
				`ATSM_IDX_TXCTL:
					txctl <= pwdata[7:0] & (8'h01 << `ATSM_FILL_BIT);
				`ATSM_IDX_PINSEL:
					pin_sel <= pwdata[7:0];
				`ATSM_IDX_CH3:
					ch3_cfg <= {1'b0, pwdata[6:0]};
				`ATSM_IDX_CH4:
					ch4_cfg <= {1'b0, pwdata[6:0]};
				`ATSM_IDX_FMT:
					fmt <= {7'h00, pwdata[`ATSM_FMT_LR_BIT]};
				default:
					fmt <= fmt;
			endcase
		end
	end
endmodule // atsm_apb

// ---- rtl/atsm_defs.vh ----
`ifndef ATSM_DEFS_VH
`define ATSM_DEFS_VH

// register indices; the byte address on the bus is four times the index
`define ATSM_IDX_TXCTL   8'h1b
`define ATSM_IDX_PINSEL  8'h1d
`define ATSM_IDX_CH3     8'h20
`define ATSM_IDX_CH4     8'h21
`define ATSM_IDX_FMT     8'h30
`define ATSM_IDX_STAT    8'h31

// reset values
`define ATSM_RST_TXCTL   8'h00
`define ATSM_RST_PINSEL  8'h00
`define ATSM_RST_CH3     8'h02
`define ATSM_RST_CH4     8'h03
`define ATSM_RST_FMT     8'h00

// field positions
`define ATSM_FILL_BIT    6
`define ATSM_RSVD_BIT    7
`define ATSM_SRC_HI      6
`define ATSM_SRC_LO      5
`define ATSM_SLOT_HI     4
`define ATSM_SLOT_LO     0
`define ATSM_FMT_LR_BIT  0
`define ATSM_CH3_BIT     2
`define ATSM_CH4_BIT     3

// source codes for channels 3 and 4
`define ATSM_SRC_TRI     2'h0
`define ATSM_SRC_MEAS    2'h2

`endif

// ---- rtl/atsm_sync.v ----
`timescale 1ns/1ps
// three-stage synchroniser; the output moves only when stages two and
// three agree, so a single-cycle glitch past the first stage is dropped
module atsm_sync #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] level
);
	reg [W-1:0] s1; // metastability catcher, read by s2 only
	reg [W-1:0] s2; // second stage
	reg [W-1:0] s3; // third stage

	// shift chain and agreement filter
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1    <= {W{1'b0}};
			s2    <= {W{1'b0}};
			s3    <= {W{1'b0}};
			level <= {W{1'b0}};
		end
		else
		begin
			s1    <= async_in;
			s2    <= s1;
			s3    <= s2;
			// take each bit whose last two stages agree
			level <= (s2 & ~(s2 ^ s3)) | (level & (s2 ^ s3));
		end
	end
endmodule // atsm_sync

// ---- rtl/atsm_top.v ----
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "atsm_defs.vh"
// What this block does
// - pin-select bit n-1 routes channel n
// - channel 3/4 source 0 means high impedance
// - channel 3 source 2 sends battery data
// - channel 4 source 2 sends temperature data
// - 5-bit slot field, TDM or left/right halves
// - channel 3 resets to slot 2, tri-state
// - channel 4 resets to slot 3, tri-state
// - pin-select resets to zero, all primary
// - bit 7 of channel configs reads zero
// - unused cycles drive zero or high impedance
module atsm_top #(
	parameter SLOT_LOG2 = 5 // log2 of bit clocks per slot
) (
	input  wire                      pclk,
	input  wire                      presetn,
	input  wire [11:0]               paddr,
	input  wire                      psel,
	input  wire                      penable,
	input  wire                      pwrite,
	input  wire [31:0]               pwdata,
	output wire [31:0]               prdata,
	output wire                      pready,
	output wire                      pslverr,
	input  wire                      bclk_pin,
	input  wire                      fsync_pin,
	input  wire [(1<<SLOT_LOG2)-1:0] vbat_data,
	input  wire [(1<<SLOT_LOG2)-1:0] temp_data,
	output reg                       primary_data_out,
	output reg                       primary_data_oe,
	output reg                       secondary_data_out_pin,
	output reg                       secondary_data_out_pin_oe,
	output wire [7:0]                tx_pin_select,
	output wire                      link_running
);
	localparam SLOT_BITS = 1 << SLOT_LOG2;  // bits in one slot
	localparam POS_W     = SLOT_LOG2 + 5;   // 32 slots of bits

	// one-hot link states
	localparam [1:0] ST_IDLE = 2'b01; // no frame seen yet, pins off
	localparam [1:0] ST_RUN  = 2'b10; // framing locked

	// register file outputs
	wire [7:0] txctl;    // holds the unused-cycle fill bit
	wire [7:0] pin_sel;  // per-channel pin select
	wire [7:0] ch3_cfg;  // channel 3 source and slot
	wire [7:0] ch4_cfg;  // channel 4 source and slot
	wire [7:0] fmt;      // frame format, bit 0 set for I2S/LJ
	wire [15:0] status;  // state shown to software

	// synchronised link levels
	wire [1:0] link_lvl; // {fsync, bclk} after filtering
	wire       bclk_lvl; // filtered bit clock
	wire       fs_lvl;   // filtered frame sync

	// edge tracking
	reg        bclk_prev; // bit clock one pclk ago
	wire       bclk_rise; // bit clock rising edge seen
	wire       bclk_fall; // bit clock falling edge seen
	reg        fs_prev;   // frame sync at the previous bclk rise
	wire       fs_rise;   // frame sync went high
	wire       fs_fall;   // frame sync went low

	// frame position
	reg  [1:0]     state;    // link state
	reg  [1:0]     next_state;
	reg  [POS_W:0] pos;      // bit position in frame or half
	reg            half;     // 0 left half, 1 right half

	// frame-stable copies of the settings and data
	reg  [7:0]           sh_pin_sel;  // active pin selects
	reg  [7:0]           sh_ch3;      // active channel 3 config
	reg  [7:0]           sh_ch4;      // active channel 4 config
	reg                  sh_fill;     // active unused-cycle fill
	reg                  sh_lr;       // active I2S/LJ format
	reg  [SLOT_BITS-1:0] sh_vbat;     // battery word of this frame
	reg  [SLOT_BITS-1:0] sh_temp;     // temperature word

	// per-cycle slot decisions
	wire       hit3;       // channel 3 owns this bit clock
	wire       hit4;       // channel 4 owns this bit clock
	wire       bit3;       // channel 3 data bit
	wire       bit4;       // channel 4 data bit
	wire [1:0] drv_pri;    // {oe, value} for the primary pin
	wire [1:0] drv_sec;    // {oe, value} for the secondary pin
	wire [SLOT_LOG2-1:0] bit_idx; // msb-first index inside a slot

	// does a 5-bit slot field own the current position
	function slot_hit;
		input [4:0]     slot;
		input [POS_W:0] p;
		input           h;
		input           lr;
		begin
			if (p[POS_W])
				slot_hit = 1'b0; // past the last slot
			else if (lr)
				slot_hit = (h == slot[4]) && !p[POS_W-1] &&
					(p[POS_W-2:SLOT_LOG2] == slot[3:0]);
			else
				slot_hit = (p[POS_W-1:SLOT_LOG2] == slot);
		end
	endfunction

	// pin drive for one pin: channel 3 wins a clash with channel 4
	function [1:0] pin_drive;
		input       on3;
		input       on4;
		input [1:0] src3;
		input [1:0] src4;
		input       d3;
		input       d4;
		input       fill;
		begin
			if (on3)
				pin_drive = (src3 == `ATSM_SRC_MEAS) ?
					{1'b1, d3} : 2'b00;
			else if (on4)
				pin_drive = (src4 == `ATSM_SRC_MEAS) ?
					{1'b1, d4} : 2'b00;
			else
				pin_drive = fill ? 2'b00 : 2'b10;
		end
	endfunction

	// register slave
	atsm_apb u_apb (
		.pclk    (pclk),
		.presetn (presetn),
		.paddr   (paddr),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.status  (status),
		.txctl   (txctl),
		.pin_sel (pin_sel),
		.ch3_cfg (ch3_cfg),
		.ch4_cfg (ch4_cfg),
		.fmt     (fmt)
	);

	// both link pins come from the host's clock domain
	atsm_sync #(
		.W (2)
	) u_sync (
		.clk      (pclk),
		.rst_n    (presetn),
		.async_in ({fsync_pin, bclk_pin}),
		.level    (link_lvl)
	);

	assign bclk_lvl  = link_lvl[0];
	assign fs_lvl    = link_lvl[1];
	assign bclk_rise = bclk_lvl & ~bclk_prev;
	assign bclk_fall = ~bclk_lvl & bclk_prev;
	assign fs_rise   = fs_lvl & ~fs_prev;
	assign fs_fall   = ~fs_lvl & fs_prev;

	// status: active pin selects above, running flag at bit 0
	assign status        = {sh_pin_sel, 7'h00, state[1]};
	assign tx_pin_select = sh_pin_sel;
	assign link_running  = state[1];

	// edge history; frame sync is only looked at on bclk rises
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bclk_prev <= 1'b0;
			fs_prev   <= 1'b0;
		end
		else
		begin
			bclk_prev <= bclk_lvl;
			if (bclk_rise)
				fs_prev <= fs_lvl;
		end
	end

	// link state: first frame sync rise starts the engine
	always @*
	begin
		case (state)
			ST_IDLE:
				next_state = (bclk_rise && fs_rise) ? ST_RUN : ST_IDLE;
			ST_RUN:
				next_state = ST_RUN;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// bit position; restarts at each frame or half boundary and
	// saturates so a missing frame sync cannot wrap into slot 0
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pos  <= {(POS_W+1){1'b0}};
			half <= 1'b0;
		end
		else if (bclk_rise)
		begin
			if (fs_rise)
			begin
				pos  <= {(POS_W+1){1'b0}};
				half <= 1'b0;
			end
			else if (fs_fall && sh_lr)
			begin
				pos  <= {(POS_W+1){1'b0}};
				half <= 1'b1;
			end
			else if (!pos[POS_W])
				pos <= pos + {{POS_W{1'b0}}, 1'b1};
		end
	end

	// settings and measurement words are taken only at frame start,
	// so a frame never mixes old and new routing
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sh_pin_sel <= `ATSM_RST_PINSEL;
			sh_ch3     <= `ATSM_RST_CH3;
			sh_ch4     <= `ATSM_RST_CH4;
			sh_fill    <= 1'b0;
			sh_lr      <= 1'b0;
			sh_vbat    <= {SLOT_BITS{1'b0}};
			sh_temp    <= {SLOT_BITS{1'b0}};
		end
		else if (bclk_rise && fs_rise)
		begin
			sh_pin_sel <= pin_sel;
			sh_ch3     <= ch3_cfg;
			sh_ch4     <= ch4_cfg;
			sh_fill    <= txctl[`ATSM_FILL_BIT];
			sh_lr      <= fmt[`ATSM_FMT_LR_BIT];
			sh_vbat    <= vbat_data;
			sh_temp    <= temp_data;
		end
	end

	// slot ownership and msb-first data bits
	assign hit3 = slot_hit(sh_ch3[`ATSM_SLOT_HI:`ATSM_SLOT_LO],
		pos, half, sh_lr);
	assign hit4 = slot_hit(sh_ch4[`ATSM_SLOT_HI:`ATSM_SLOT_LO],
		pos, half, sh_lr);
	assign bit_idx = ~pos[SLOT_LOG2-1:0];
	assign bit3 = sh_vbat[bit_idx];
	assign bit4 = sh_temp[bit_idx];

	// route each channel to the pin its select bit names
	assign drv_pri = pin_drive(
		hit3 & ~sh_pin_sel[`ATSM_CH3_BIT],
		hit4 & ~sh_pin_sel[`ATSM_CH4_BIT],
		sh_ch3[`ATSM_SRC_HI:`ATSM_SRC_LO],
		sh_ch4[`ATSM_SRC_HI:`ATSM_SRC_LO],
		bit3, bit4, sh_fill);
	assign drv_sec = pin_drive(
		hit3 & sh_pin_sel[`ATSM_CH3_BIT],
		hit4 & sh_pin_sel[`ATSM_CH4_BIT],
		sh_ch3[`ATSM_SRC_HI:`ATSM_SRC_LO],
		sh_ch4[`ATSM_SRC_HI:`ATSM_SRC_LO],
		bit3, bit4, sh_fill);

	// pins change on bclk falls so the host samples a settled bit on
	// the following rise; until the first frame the pins stay off
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			primary_data_out          <= 1'b0;
			primary_data_oe           <= 1'b0;
			secondary_data_out_pin    <= 1'b0;
			secondary_data_out_pin_oe <= 1'b0;
		end
		else if (bclk_fall)
		begin
			if (state == ST_RUN)
			begin
				primary_data_oe           <= drv_pri[1];
				primary_data_out          <= drv_pri[0];
				secondary_data_out_pin_oe <= drv_sec[1];
				secondary_data_out_pin    <= drv_sec[0];
			end
			else
			begin
				primary_data_oe           <= 1'b0;
				primary_data_out          <= 1'b0;
				secondary_data_out_pin_oe <= 1'b0;
				secondary_data_out_pin    <= 1'b0;
			end
		end
	end
endmodule // atsm_top

// ---- tb/atsm_host.sv ----
`timescale 1ns/1ps
// host side: makes bit clock and frame sync, records both data pins
module atsm_host #(
	parameter NB = 128 // bit clocks in one frame
) (
	output logic bclk,
	output logic fsync,
	input  wire  d0,
	input  wire  oe0,
	input  wire  d1,
	input  wire  oe1
);
	logic cap0 [0:NB-1]; // primary pin, one entry per bit
	logic cap1 [0:NB-1]; // secondary pin, one entry per bit
	// clock stands low between frames
	initial
	begin
		bclk = 1'b0;
		fsync = 1'b0;
	end
	// sync moves a half bit ahead of the rise; a bit is read at the
	// fall that ends it, since the pin lags each fall by a few pclk
	task automatic frame();
		#37;
		for (int i = 0; i <= NB; i++)
		begin
			fsync = (i < NB / 2);
			#400 bclk = 1'b1;
			#400 bclk = 1'b0;
			if (i > 0)
			begin
				cap0[i-1] = oe0 ? d0 : 1'bz;
				cap1[i-1] = oe1 ? d1 : 1'bz;
			end
		end
	endtask
endmodule // atsm_host

// ---- tb/atsm_top_props.sv ----
`timescale 1ns/1ps
// port watcher: bus answer, pin timing, frame-aligned settings
module atsm_top_chk #(
	parameter SLOT_LOG2 = 5 // slot length, kept equal to the design
) (
	input wire        pclk,
	input wire        presetn,
	input wire [11:0] paddr,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        bclk_pin,
	input wire        fsync_pin,
	input wire        primary_data_out,
	input wire        primary_data_oe,
	input wire        secondary_data_out_pin,
	input wire        secondary_data_out_pin_oe,
	input wire [7:0]  tx_pin_select,
	input wire        link_running
);
	reg [1:0] bq;         // bit clock resampled
	reg [1:0] fq;         // frame sync resampled
	reg [7:0] since_fall; // pclk since a bit clock fall
	reg [7:0] since_fs;   // pclk since a frame sync rise
	// two flops suffice: only the rough age of each edge matters
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bq <= 2'b00;
			fq <= 2'b00;
			since_fall <= 8'hff;
			since_fs <= 8'hff;
		end
		else
		begin
			bq <= {bq[0], bclk_pin};
			fq <= {fq[0], fsync_pin};
			if (bq == 2'b10)
				since_fall <= 8'h00;
			else if (since_fall != 8'hff)
				since_fall <= since_fall + 8'h01;
			if (fq == 2'b01)
				since_fs <= 8'h00;
			else if (since_fs != 8'hff)
				since_fs <= since_fs + 8'h01;
		end
	end
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_no_wait: assert property (psel && penable |-> pready)
		else $error("pready low in an access phase");
	chk_err_phase: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside an access phase");
	chk_err_align: assert property (
		psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("misaligned access not refused");
	chk_rdata_hold: assert property (
		psel && !penable && !pwrite |=> ##1 $stable(prdata))
		else $error("read data moved after the access");
	chk_link_sticky: assert property (link_running |=> link_running)
		else $error("link dropped without reset");
	chk_pins_idle: assert property (
		!link_running |-> !primary_data_oe && !secondary_data_out_pin_oe
		&& tx_pin_select == 8'h00)
		else $error("pins active before the first frame");
	chk_pin_timing: assert property (
		$changed({primary_data_out, primary_data_oe, secondary_data_out_pin,
		secondary_data_out_pin_oe}) |-> since_fall < 8'h08)
		else $error("data pins moved away from a bit clock fall");
	chk_frame_latch: assert property (
		$changed(tx_pin_select) |-> since_fs < 8'h10)
		else $error("pin select changed inside a frame");
	cover property ($rose(link_running));
	cover property (psel && penable && pslverr);
	cover property (secondary_data_out_pin_oe && secondary_data_out_pin);
endmodule // atsm_top_chk

bind atsm_top atsm_top_chk #(.SLOT_LOG2(SLOT_LOG2)) u_chk (.pclk(pclk),
	.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.bclk_pin(bclk_pin), .fsync_pin(fsync_pin),
	.primary_data_out(primary_data_out), .primary_data_oe(primary_data_oe),
	.secondary_data_out_pin(secondary_data_out_pin),
	.secondary_data_out_pin_oe(secondary_data_out_pin_oe),
	.tx_pin_select(tx_pin_select), .link_running(link_running));

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`include "atsm_defs.vh"
module tb_top;
	localparam NB = 128; // 32 slots of 4 bits
	logic        pclk, presetn, psel, penable, pwrite, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	logic [3:0]  vbat, temp;
	wire  [31:0] prdata;
	wire  [7:0]  act;
	wire         pready, pslverr, bclk, fsync, d0, oe0, d1, oe1, run;
	int          mismatches, checked, cyc;
	// per setting: fill, pin select, ch3, ch4, format
	// sources stay 0 or 2 and bit 7 of ch3 and ch4 stays clear
	logic [7:0]  cfg [0:4][0:4] = '{'{8'h00, 8'h00, 8'h02, 8'h03, 8'h00},
		'{8'h40, 8'h08, 8'h5f, 8'h40, 8'h00}, '{8'h00, 8'h04, 8'h50, 8'h4f, 8'h01},
		'{8'h00, 8'h0c, 8'h07, 8'h49, 8'h00}, '{8'h00, 8'hf3, 8'h5f, 8'h5e, 8'h01}};
	logic [7:0]  ridx [0:4] = '{`ATSM_IDX_TXCTL, `ATSM_IDX_PINSEL,
		`ATSM_IDX_CH3, `ATSM_IDX_CH4, `ATSM_IDX_FMT};
	atsm_top #(.SLOT_LOG2(2)) DUT (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bclk_pin(bclk), .fsync_pin(fsync), .vbat_data(vbat), .temp_data(temp),
		.primary_data_out(d0), .primary_data_oe(oe0),
		.secondary_data_out_pin(d1), .secondary_data_out_pin_oe(oe1),
		.tx_pin_select(act), .link_running(run));
	atsm_host #(.NB(NB)) host (.bclk(bclk), .fsync(fsync), .d0(d0),
		.oe0(oe0), .d1(d1), .oe1(oe1));
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// hang guard: 20000 cycles, over nineteen frames' worth
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			mismatches++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (mismatches == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] x, logic [31:0] g);
		checked++;
		if (g !== x)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask
	// one apb transfer, held until pready is seen high
	task automatic apb(logic w, logic [11:0] a, logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(logic [7:0] i, logic [31:0] d);
		apb(1'b1, {2'b00, i, 2'b00}, d);
	endtask
	task automatic rdc(string n, logic [7:0] i, logic [31:0] x);
		apb(1'b0, {2'b00, i, 2'b00}, 32'h0);
		chk(n, x, rd);
	endtask
	task automatic put(int k);
		for (int r = 0; r < 5; r++)
			wr(ridx[r], {24'h0, cfg[k][r]});
	endtask
	// pin level the host should see at bit p under setting k
	function automatic logic expbit(int k, int pin, int p);
		logic [7:0] c3, c4;
		int q, s, b;
		c3 = cfg[k][2];
		c4 = cfg[k][3];
		q = cfg[k][4][0] ? p % (NB / 2) : p;
		s = q / 4 + ((cfg[k][4][0] && p >= NB / 2) ? 16 : 0);
		b = 3 - q % 4;
		if (c3[4:0] == s && cfg[k][1][2] == pin)
			return (c3[6:5] == 2'h2) ? vbat[b] : 1'bz;
		if (c4[4:0] == s && cfg[k][1][3] == pin)
			return (c4[6:5] == 2'h2) ? temp[b] : 1'bz;
		return cfg[k][0][6] ? 1'bz : 1'b0;
	endfunction
	task automatic t_reset();
		chk("pin_enables", 32'h0, {oe0, oe1});
		rdc("pin_select", `ATSM_IDX_PINSEL, 32'h0);
		rdc("ch3_cfg", `ATSM_IDX_CH3, 32'h2);
		rdc("ch4_cfg", `ATSM_IDX_CH4, 32'h3);
		rdc("status", `ATSM_IDX_STAT, 32'h0);
		chk("link_running", 32'h0, {31'h0, run});
	endtask
	task automatic t_regs();
		wr(`ATSM_IDX_CH3, 32'h5f);
		rdc("ch3_cfg", `ATSM_IDX_CH3, 32'h5f);
		wr(`ATSM_IDX_CH4, 32'h4a);
		rdc("ch4_cfg", `ATSM_IDX_CH4, 32'h4a);
		wr(`ATSM_IDX_TXCTL, 32'hff);
		rdc("txctl", `ATSM_IDX_TXCTL, 32'h40);
		wr(`ATSM_IDX_FMT, 32'hff);
		rdc("fmt", `ATSM_IDX_FMT, 32'h01);
		wr(`ATSM_IDX_PINSEL, 32'ha5);
		apb(1'b1, 12'h075, 32'hff);
		chk("pslverr", 32'h1, {31'h0, e});
		rdc("pin_select", `ATSM_IDX_PINSEL, 32'ha5);
	endtask
	// settings 1 to 4 are written mid-frame and must wait for the next one
	task automatic t_frames();
		put(0);
		for (int k = 1; k <= 5; k++)
		begin
			fork
				host.frame();
				if (k < 5)
				begin
					repeat (100) @(posedge pclk);
					put(k);
				end
			join
			for (int p = 0; p < NB; p++)
			begin
				chk("primary_pin", expbit(k-1, 0, p), host.cap0[p]);
				chk("secondary_pin", expbit(k-1, 1, p), host.cap1[p]);
			end
			chk("active_select", cfg[k-1][1], act);
		end
		chk("link_running", 32'h1, {31'h0, run});
		rdc("status", `ATSM_IDX_STAT, {16'h0, cfg[4][1], 8'h01});
	endtask
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		vbat = 4'hb;
		temp = 4'h6;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_regs();
		t_frames();
		complete_run();
	end
endmodule // tb_top
